/* ssr_pkg.sv */
// Constants and types shared by the status reporting block.
// Assumes a single clock domain and synchronous reset.
package ssr_pkg;

  localparam int          SSR_GRP_W      = 16;
  localparam int          SSR_SSB_W      = 8;
  localparam logic [15:0] SSR_GRP_RST    = 16'h0000;
  localparam logic [15:0] SSR_GRP_MASK   = 16'h7fff;
  localparam logic [7:0]  SSR_SSB_RST    = 8'h00;
  localparam logic [7:0]  SSR_SRM_USED   = 8'hbf;

  // Status byte bit positions
  localparam int          SSR_BIT_ERRQ   = 2;
  localparam int          SSR_BIT_QUES   = 3;
  localparam int          SSR_BIT_MSGP   = 4;
  localparam int          SSR_BIT_ESUM   = 5;
  localparam int          SSR_BIT_MSF    = 6;
  localparam int          SSR_BIT_OPER   = 7;

  // Register select codes on the access port
  localparam logic [3:0]  SSR_SEL_SSB    = 4'h0;
  localparam logic [3:0]  SSR_SEL_SRM    = 4'h1;
  localparam logic [3:0]  SSR_SEL_SEVT   = 4'h2;
  localparam logic [3:0]  SSR_SEL_SMSK   = 4'h3;
  localparam logic [3:0]  SSR_SEL_OCOND  = 4'h4;
  localparam logic [3:0]  SSR_SEL_OEVT   = 4'h5;
  localparam logic [3:0]  SSR_SEL_OENA   = 4'h6;
  localparam logic [3:0]  SSR_SEL_ORISE  = 4'h7;
  localparam logic [3:0]  SSR_SEL_OFALL  = 4'h8;
  localparam logic [3:0]  SSR_SEL_QCOND  = 4'h9;
  localparam logic [3:0]  SSR_SEL_QEVT   = 4'ha;
  localparam logic [3:0]  SSR_SEL_QENA   = 4'hb;
  localparam logic [3:0]  SSR_SEL_QRISE  = 4'hc;
  localparam logic [3:0]  SSR_SEL_QFALL  = 4'hd;

  // Part select within a group
  localparam logic [2:0]  SSR_PART_COND  = 3'h0;
  localparam logic [2:0]  SSR_PART_EVT   = 3'h1;
  localparam logic [2:0]  SSR_PART_ENA   = 3'h2;
  localparam logic [2:0]  SSR_PART_RISE  = 3'h3;
  localparam logic [2:0]  SSR_PART_FALL  = 3'h4;

  typedef enum logic [2:0] {
    SSR_SRQ_IDLE = 3'b001,
    SSR_SRQ_RAISE = 3'b010,
    SSR_SRQ_HOLD = 3'b100
  } ssr_srq_st_t;

endpackage : ssr_pkg

/* ssr_group.sv */
// One five-part status group: condition, edge selects, event latch, enable.
// Assumes condition inputs are already synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module ssr_group
  import ssr_pkg::*;
(
  input  wire logic        clk,       // System clock
  input  wire logic        rst_n,     // Synchronous reset, active low
  input  wire logic [15:0] cond_in,   // Live condition bits
  input  wire logic        wr_en,     // Write strobe
  input  wire logic        rd_en,     // Read strobe
  input  wire logic [2:0]  part,      // Part select
  input  wire logic [15:0] wr_data,   // Write data
  output logic      [15:0] rd_data,   // Read data (combinational)
  output logic             sum_bit    // Masked OR of events
);

  logic [15:0] cond_q;
  logic [15:0] rise_q;
  logic [15:0] fall_q;
  logic [15:0] event_q;
  logic [15:0] enable_q;
  logic [15:0] edge_hit;

  // ==========================================================
  // Condition tracking
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_q <= SSR_GRP_RST;
    end else begin
      cond_q <= cond_in & SSR_GRP_MASK;
    end
  end

  assign edge_hit = ((~cond_q & cond_in & rise_q)
                    | (cond_q & ~cond_in & fall_q)) & SSR_GRP_MASK;

  // ==========================================================
  // Software writable parts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise_q   <= SSR_GRP_RST;
      fall_q   <= SSR_GRP_RST;
      enable_q <= SSR_GRP_RST;
    end else if (wr_en) begin
      case (part)
        SSR_PART_RISE: rise_q   <= wr_data & SSR_GRP_MASK;
        SSR_PART_FALL: fall_q   <= wr_data & SSR_GRP_MASK;
        SSR_PART_ENA:  enable_q <= wr_data & SSR_GRP_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Event latch, cleared by read, new edges win
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      event_q <= SSR_GRP_RST;
    end else if (rd_en && part == SSR_PART_EVT) begin
      event_q <= edge_hit;
    end else begin
      event_q <= event_q | edge_hit;
    end
  end

  assign sum_bit = |(event_q & enable_q);

  always_comb begin
    case (part)
      SSR_PART_COND: rd_data = cond_q;
      SSR_PART_EVT:  rd_data = event_q;
      SSR_PART_ENA:  rd_data = enable_q;
      SSR_PART_RISE: rd_data = rise_q;
      SSR_PART_FALL: rd_data = fall_q;
      default:       rd_data = SSR_GRP_RST;
    endcase
  end

endmodule : ssr_group
`default_nettype wire

/* ssr_std_event.sv */
// Standard event latch and its mask (eight bits, set by pulses).
// Assumes event pulses are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module ssr_std_event
  import ssr_pkg::*;
(
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Synchronous reset, active low
  input  wire logic [7:0] set_pulse, // Event set pulses
  input  wire logic       rd_clr,    // Read of latch, clears it
  input  wire logic       mask_wr,   // Mask write strobe
  input  wire logic [7:0] wr_data,   // Mask write data
  output logic      [7:0] latch,     // Latch contents
  output logic      [7:0] mask,      // Mask contents
  output logic            summary    // Masked OR
);

  logic [7:0] latch_q;
  logic [7:0] mask_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_q <= SSR_SSB_RST;
    end else if (rd_clr) begin
      latch_q <= set_pulse;
    end else begin
      latch_q <= latch_q | set_pulse;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= SSR_SSB_RST;
    end else if (mask_wr) begin
      mask_q <= wr_data;
    end
  end

  assign latch   = latch_q;
  assign mask    = mask_q;
  assign summary = |(latch_q & mask_q);

endmodule : ssr_std_event
`default_nettype wire

/* ssr_top.sv */
// Status reporting top: operation and questionable groups, standard
// event latch, status byte, request mask and service request output.
// Assumes status pins are asynchronous; access port is on clk.
`timescale 1ns/1ns
`default_nettype none
module ssr_top
  import ssr_pkg::*;
(
  input  wire logic        clk,               // System clock, 20 MHz
  input  wire logic        rst_n,             // Synchronous reset, active low
  input  wire logic [15:0] oper_status,       // Operation hardware status
  input  wire logic [15:0] ques_status,       // Questionable hardware status
  input  wire logic [7:0]  std_event_set,     // Standard event pulses
  input  wire logic        error_queued,      // Error queue not empty
  input  wire logic        output_message_pending, // Output buffer has data
  input  wire logic        serial_poll,       // Serial poll strobe
  input  wire logic        reg_wr,            // Register write strobe
  input  wire logic        reg_rd,            // Register read strobe
  input  wire logic [3:0]  reg_sel,           // Register select
  input  wire logic [15:0] reg_wdata,         // Write data
  output logic      [15:0] reg_rdata,         // Read data, registered
  output logic             reg_rvalid,        // Read data valid pulse
  output logic      [7:0]  poll_byte,         // Serial poll answer
  output logic             poll_valid,        // Poll answer pulse
  output logic             service_request    // Bus service request
);

  // ==========================================================
  // Pin synchronisers
  logic [15:0] oper_s1_q, oper_s2_q, ques_s1_q, ques_s2_q;
  logic        errq_s1_q, errq_s2_q, msgp_s1_q, msgp_s2_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oper_s1_q <= SSR_GRP_RST;
      oper_s2_q <= SSR_GRP_RST;
      ques_s1_q <= SSR_GRP_RST;
      ques_s2_q <= SSR_GRP_RST;
      errq_s1_q <= 1'b0;
      errq_s2_q <= 1'b0;
      msgp_s1_q <= 1'b0;
      msgp_s2_q <= 1'b0;
    end else begin
      oper_s1_q <= oper_status;
      oper_s2_q <= oper_s1_q;
      ques_s1_q <= ques_status;
      ques_s2_q <= ques_s1_q;
      errq_s1_q <= error_queued;
      errq_s2_q <= errq_s1_q;
      msgp_s1_q <= output_message_pending;
      msgp_s2_q <= msgp_s1_q;
    end
  end

  // ==========================================================
  // Access decode
  function automatic logic in_range(input logic [3:0] s, input logic [3:0] lo, input logic [3:0] hi);
    in_range = (s >= lo) && (s <= hi);
  endfunction : in_range

  function automatic logic [2:0] part_of(input logic [3:0] s, input logic [3:0] base);
    logic [3:0] d;
    d = s - base;
    part_of = d[2:0];
  endfunction : part_of

  logic        oper_hit, ques_hit;
  logic [2:0]  oper_part, ques_part;
  logic [15:0] oper_rd, ques_rd;
  logic        oper_sum, ques_sum;

  assign oper_hit  = in_range(reg_sel, SSR_SEL_OCOND, SSR_SEL_OFALL);
  assign ques_hit  = in_range(reg_sel, SSR_SEL_QCOND, SSR_SEL_QFALL);
  assign oper_part = part_of(reg_sel, SSR_SEL_OCOND);
  assign ques_part = part_of(reg_sel, SSR_SEL_QCOND);

  // ==========================================================
  // Lower groups
  ssr_group u_oper (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond_in (oper_s2_q),
    .wr_en   (reg_wr && oper_hit),
    .rd_en   (reg_rd && oper_hit),
    .part    (oper_part),
    .wr_data (reg_wdata),
    .rd_data (oper_rd),
    .sum_bit (oper_sum)
  );

  ssr_group u_ques (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond_in (ques_s2_q),
    .wr_en   (reg_wr && ques_hit),
    .rd_en   (reg_rd && ques_hit),
    .part    (ques_part),
    .wr_data (reg_wdata),
    .rd_data (ques_rd),
    .sum_bit (ques_sum)
  );

  logic [7:0] std_latch, std_mask;
  logic       standard_event_summary;

  ssr_std_event u_std (
    .clk       (clk),
    .rst_n     (rst_n),
    .set_pulse (std_event_set),
    .rd_clr    (reg_rd && reg_sel == SSR_SEL_SEVT),
    .mask_wr   (reg_wr && reg_sel == SSR_SEL_SMSK),
    .wr_data   (reg_wdata[7:0]),
    .latch     (std_latch),
    .mask      (std_mask),
    .summary   (standard_event_summary)
  );

  // ==========================================================
  // Status byte and request mask
  logic [7:0] service_request_mask_q;
  logic [7:0] status_base;
  logic [7:0] summary_status_byte;
  logic       master_summary_flag;
  logic [7:0] status_prev_q;
  logic       srq_edge;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      service_request_mask_q <= SSR_SSB_RST;
    end else if (reg_wr && reg_sel == SSR_SEL_SRM) begin
      service_request_mask_q <= reg_wdata[7:0];
    end
  end

  always_comb begin
    status_base               = SSR_SSB_RST;
    status_base[SSR_BIT_ERRQ] = errq_s2_q;
    status_base[SSR_BIT_QUES] = ques_sum;
    status_base[SSR_BIT_MSGP] = msgp_s2_q;
    status_base[SSR_BIT_ESUM] = standard_event_summary;
    status_base[SSR_BIT_OPER] = oper_sum;
  end

  assign master_summary_flag = |(status_base & service_request_mask_q & SSR_SRM_USED);

  always_comb begin
    summary_status_byte              = status_base;
    summary_status_byte[SSR_BIT_MSF] = master_summary_flag;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_prev_q <= SSR_SSB_RST;
    end else begin
      status_prev_q <= status_base;
    end
  end

  // Rising masked bit, includes the error queue turning non-empty when bit 2 enabled
  assign srq_edge = |(status_base & ~status_prev_q & service_request_mask_q & SSR_SRM_USED);

  // ==========================================================
  // Service request sequencing
  ssr_srq_st_t srq_st_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      srq_st_q <= SSR_SRQ_IDLE;
    end else begin
      case (srq_st_q)
        SSR_SRQ_IDLE:  if (srq_edge) srq_st_q <= SSR_SRQ_RAISE;
        SSR_SRQ_RAISE: srq_st_q <= SSR_SRQ_HOLD;
        SSR_SRQ_HOLD:  if (!master_summary_flag && !srq_edge) srq_st_q <= SSR_SRQ_IDLE;
        default:       srq_st_q <= SSR_SRQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      service_request <= 1'b0;
    end else begin
      service_request <= (srq_st_q != SSR_SRQ_IDLE) || srq_edge;
    end
  end

  // ==========================================================
  // Read path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata  <= SSR_GRP_RST;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (oper_hit) begin
          reg_rdata <= oper_rd;
        end else if (ques_hit) begin
          reg_rdata <= ques_rd;
        end else begin
          case (reg_sel)
            SSR_SEL_SSB:  reg_rdata <= {8'h00, summary_status_byte};
            SSR_SEL_SRM:  reg_rdata <= {8'h00, service_request_mask_q};
            SSR_SEL_SEVT: reg_rdata <= {8'h00, std_latch};
            SSR_SEL_SMSK: reg_rdata <= {8'h00, std_mask};
            default:     reg_rdata <= SSR_GRP_RST;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      poll_byte  <= SSR_SSB_RST;
      poll_valid <= 1'b0;
    end else begin
      poll_valid <= serial_poll;
      if (serial_poll) begin
        poll_byte <= summary_status_byte;
      end
    end
  end

endmodule : ssr_top
`default_nettype wire

/* ssr_checker.sv */
// Concurrent checks on the status reporting top ports.
// Assumes one clock domain; attached to ssr_top by bind.
`timescale 1ns/1ns
`default_nettype none
module ssr_checker
  import ssr_pkg::*;
(
  input wire logic        clk,                    // Clock
  input wire logic        rst_n,                  // Reset
  input wire logic [15:0] oper_status,            // Status
  input wire logic [15:0] ques_status,            // Status
  input wire logic [7:0]  std_event_set,          // Pulses
  input wire logic        error_queued,           // Level
  input wire logic        output_message_pending, // Level
  input wire logic        serial_poll,            // Poll
  input wire logic        reg_wr,                 // Write
  input wire logic        reg_rd,                 // Read
  input wire logic [3:0]  reg_sel,                // Select
  input wire logic [15:0] reg_wdata,              // Data
  input wire logic [15:0] reg_rdata,              // Data
  input wire logic        reg_rvalid,             // Valid
  input wire logic [7:0]  poll_byte,              // Poll answer
  input wire logic        poll_valid,             // Poll valid
  input wire logic        service_request         // Request
);
  // ==========================================================
  // Access port and poll answers
  a_rvalid_after_rd: assert property (@(posedge clk) disable iff (!rst_n) reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_only_rd: assert property (@(posedge clk) disable iff (!rst_n) reg_rvalid |-> $past(reg_rd))
    else $error("stray read valid");
  a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_n) !reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved");
  a_poll_answer: assert property (@(posedge clk) disable iff (!rst_n) serial_poll |=> poll_valid)
    else $error("poll not answered");
  a_poll_byte_holds: assert property (@(posedge clk) disable iff (!rst_n) !poll_valid |-> $stable(poll_byte))
    else $error("poll byte moved");
  a_bit15_zero: assert property (@(posedge clk) disable iff (!rst_n) reg_rvalid |-> reg_rdata[15] == 1'b0)
    else $error("bit 15 set");
  a_byte_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_sel <= SSR_SEL_SMSK |=> reg_rdata[15:8] == 8'h00)
    else $error("upper byte set");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_sel >= 4'he |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // ==========================================================
  // Service request
  a_srq_min_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(service_request) |-> service_request [*2])
    else $error("request too short");
  a_reset_quiet: assert property (@(posedge clk) !rst_n |=> !service_request && !reg_rvalid && !poll_valid)
    else $error("outputs active in reset");
  c_srq: cover property (@(posedge clk) $rose(service_request));
  c_poll: cover property (@(posedge clk) poll_valid);
  c_unmapped: cover property (@(posedge clk) reg_rd && reg_sel == 4'hf);
endmodule : ssr_checker

bind ssr_top ssr_checker u_chk (
  .clk                    (clk),
  .rst_n                  (rst_n),
  .oper_status            (oper_status),
  .ques_status            (ques_status),
  .std_event_set          (std_event_set),
  .error_queued           (error_queued),
  .output_message_pending (output_message_pending),
  .serial_poll            (serial_poll),
  .reg_wr                 (reg_wr),
  .reg_rd                 (reg_rd),
  .reg_sel                (reg_sel),
  .reg_wdata              (reg_wdata),
  .reg_rdata              (reg_rdata),
  .reg_rvalid             (reg_rvalid),
  .poll_byte              (poll_byte),
  .poll_valid             (poll_valid),
  .service_request        (service_request)
);
`default_nettype wire

/* ssr_ctl_model.sv */
// Bus controller model: answers each new service request with a serial poll.
// Assumes the bench sets the poll delay and checks the answer.
`timescale 1ns/1ns
`default_nettype none
module ssr_ctl_model (
  input  wire logic       clk,             // Clock
  input  wire logic       rst_n,           // Reset
  input  wire logic       service_request, // From device
  input  wire logic [3:0] poll_delay,      // Cycles before poll
  output logic            serial_poll      // Poll strobe
);
  logic srq_q;
  int   wait_q;
  // Poll once per rising request, after the chosen delay
  always @(negedge clk) begin
    if (!rst_n) begin
      srq_q       <= 1'b0;
      wait_q      <= 0;
      serial_poll <= 1'b0;
    end else begin
      if (wait_q > 0) wait_q <= wait_q - 1;
      if (service_request && !srq_q) wait_q <= int'(poll_delay) + 1;
      serial_poll <= (wait_q == 1);
      srq_q <= service_request;
    end
  end
endmodule : ssr_ctl_model
`default_nettype wire

/* ssr_top_tb_top.sv */
// Self-checking bench for the status reporting top.
// Assumes the bound checker and the controller model beside the design.
`timescale 1ns/1ns
`default_nettype none
module ssr_top_tb_top
  import ssr_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] oper_status = 16'h0000;
  logic [15:0] ques_status = 16'h0000;
  logic [7:0]  std_event_set = 8'h00;
  logic        error_queued = 1'b0;
  logic        output_message_pending = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_sel = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [3:0]  poll_delay = 4'h1;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic [7:0]  poll_byte;
  logic        poll_valid;
  logic        service_request;
  logic        serial_poll;
  logic [31:0] rd_q[$];
  logic [15:0] pl_q[$];
  logic [31:0] e;
  logic [15:0] v;
  logic [7:0]  sb;
  logic [3:0]  b;
  int          errors = 0;
  int          checked = 0;
  int          seed = 63;
  localparam logic [3:0]  rw_sel [8] = '{4'h1, 4'h3, 4'h6, 4'h7, 4'h8, 4'hb, 4'hc, 4'hd};
  localparam logic [15:0] rw_wm [8] = '{16'h00bf, 16'hffff, 16'hffff, 16'hffff,
                                        16'hffff, 16'hffff, 16'hffff, 16'hffff};
  localparam logic [15:0] rw_em [8] = '{16'h00bf, 16'h00ff, 16'h7fff, 16'h7fff,
                                        16'h7fff, 16'h7fff, 16'h7fff, 16'h7fff};
  localparam int          sb_pos [5] = '{7, 3, 5, 2, 4};

  always #25 clk = ~clk;
  ssr_top dut (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .oper_status            (oper_status),
    .ques_status            (ques_status),
    .std_event_set          (std_event_set),
    .error_queued           (error_queued),
    .output_message_pending (output_message_pending),
    .serial_poll            (serial_poll),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_sel                (reg_sel),
    .reg_wdata              (reg_wdata),
    .reg_rdata              (reg_rdata),
    .reg_rvalid             (reg_rvalid),
    .poll_byte              (poll_byte),
    .poll_valid             (poll_valid),
    .service_request        (service_request)
  );
  ssr_ctl_model u_ctl (
    .clk             (clk),
    .rst_n           (rst_n),
    .service_request (service_request),
    .poll_delay      (poll_delay),
    .serial_poll     (serial_poll)
  );

  // ==========================================================
  // Driver and compare tasks
  task automatic compare_rd(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t read data got %h exp %h", $time, got, exp);
    end
  endtask : compare_rd
  task automatic compare_poll(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t poll byte got %h exp %h", $time, got, exp);
    end
  endtask : compare_poll
  task automatic compare_level(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : compare_level
  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    @(negedge clk);
    reg_sel = sel;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] sel, input logic [15:0] m, input logic [15:0] x,
                    input logic [7:0] ev = 8'h00);
    rd_q.push_back({m, x});
    @(negedge clk);
    reg_sel = sel;
    reg_rd = 1'b1;
    std_event_set = ev;
    @(negedge clk);
    reg_rd = 1'b0;
    std_event_set = 8'h00;
  endtask : rd
  task automatic pulse(input logic [7:0] ev);
    @(negedge clk);
    std_event_set = ev;
    @(negedge clk);
    std_event_set = 8'h00;
  endtask : pulse
  task automatic results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Monitor: oldest note against each answer
  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      e = (rd_q.size() != 0) ? rd_q.pop_front() : 32'hffff_dead;
      compare_rd(reg_rdata & e[31:16], e[15:0]);
    end
    if (poll_valid === 1'b1) begin
      v = (pl_q.size() != 0) ? pl_q.pop_front() : 16'hdead;
      compare_poll(poll_byte, v[7:0]);
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int s = 0; s < 16; s++) rd(4'(s), 16'hffff, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      v = 16'($random(seed));
      wr(rw_sel[i], v & rw_wm[i]);
      rd(rw_sel[i], 16'hffff, v & rw_em[i]);
      rd(rw_sel[i], 16'hffff, v & rw_em[i]);
      wr(rw_sel[i], 16'h0000);
    end
    for (int g = 0; g < 2; g++) begin
      b = g ? 4'h9 : 4'h4;
      wr(b + 4'h3, 16'h0f0f);
      wr(b + 4'h4, 16'h00ff);
      v = 16'($random(seed));
      wr(b, v);
      if (g) ques_status = v; else oper_status = v;
      repeat (6) @(negedge clk);
      rd(b, 16'hffff, v & 16'h7fff);
      rd(b + 4'h1, 16'hffff, v & 16'h0f0f);
      rd(b + 4'h1, 16'hffff, 16'h0000);
      if (g) ques_status = 16'h0000; else oper_status = 16'h0000;
      repeat (6) @(negedge clk);
      rd(b + 4'h1, 16'hffff, v & 16'h00ff);
      wr(b + 4'h2, 16'h7fff);
      wr(b + 4'h3, 16'h7fff);
      wr(b + 4'h4, 16'h0000);
    end
    wr(4'h3, 16'h00ff);
    wr(4'h1, 16'h00bf);
    for (int k = 0; k < 5; k++) begin
      sb = 8'h01 << sb_pos[k];
      poll_delay = 4'($random(seed)) | 4'h1;
      pl_q.push_back({8'h00, sb | 8'h40});
      case (k)
        0: oper_status = 16'h0001;
        1: ques_status = 16'h0001;
        2: pulse(8'h01);
        3: error_queued = 1'b1;
        default: output_message_pending = 1'b1;
      endcase
      repeat (30) @(negedge clk);
      rd(4'h0, 16'h00ff, {8'h00, sb | 8'h40});
      case (k)
        0: rd(4'h5, 16'hffff, 16'h0001);
        1: rd(4'ha, 16'hffff, 16'h0001);
        2: rd(4'h2, 16'hffff, 16'h0001);
        3: error_queued = 1'b0;
        default: output_message_pending = 1'b0;
      endcase
      oper_status = 16'h0000;
      ques_status = 16'h0000;
      repeat (10) @(negedge clk);
      compare_level({15'h0000, service_request}, 16'h0000, "request released");
      rd(4'h0, 16'h00ff, 16'h0000);
    end
    wr(4'h1, 16'h0040);
    pulse(8'h01);
    repeat (20) @(negedge clk);
    compare_level({15'h0000, service_request}, 16'h0000, "mask bit 6 used");
    rd(4'h0, 16'h00ff, 16'h0020);
    rd(4'h2, 16'hffff, 16'h0001);
    pulse(8'h02);
    rd(4'h2, 16'hfffe, 16'h0002, 8'h01);
    rd(4'h2, 16'hffff, 16'h0001);
    repeat (5) @(negedge clk);
    compare_level(16'(rd_q.size() + pl_q.size()), 16'h0000, "answers missing");
    results();
  end
endmodule : ssr_top_tb_top
`default_nettype wire
